// ### shared/dsib_pkg.sv
package dsib_pkg;

  // core clock and derived bit periods
  localparam int CLK_HZ = 20_000_000;
  localparam int BAUD_9600 = 9600;
  localparam int BAUD_4800 = 4800;
  localparam int BAUD_2400 = 2400;
  localparam int BAUD_1200 = 1200;
  localparam int DIV_9600 = CLK_HZ / BAUD_9600;
  localparam int DIV_4800 = CLK_HZ / BAUD_4800;
  localparam int DIV_2400 = CLK_HZ / BAUD_2400;
  localparam int DIV_1200 = CLK_HZ / BAUD_1200;
  localparam int DIV_W = 15;

  // baud select codes, {upper switch, lower switch}, on = 1
  localparam logic [1:0] BAUD_SEL_9600 = 2'h3;
  localparam logic [1:0] BAUD_SEL_4800 = 2'h2;
  localparam logic [1:0] BAUD_SEL_2400 = 2'h1;

  // switch positions in the configuration switch bank (switch n at bit n-1)
  localparam int SW_GPS_OFF = 0;
  localparam int SW_COMP_OFF = 1;
  localparam int SW_ADDR = 2;
  localparam int SW_GPS_BAUD_LO = 3;
  localparam int SW_GPS_BAUD_HI = 4;
  localparam int SW_COMP_BAUD_LO = 5;
  localparam int SW_COMP_BAUD_HI = 6;
  localparam logic [7:0] SW_RST = 8'hFF;

  // port indices
  localparam int PORT_COMP = 0;
  localparam int PORT_GPS = 1;
  localparam int NPORTS = 2;

  // serial character: 8 data bits, no parity, 1 stop
  localparam logic [3:0] UART_LAST_BIT = 4'h9;
  localparam logic [3:0] TX_SHIFTS = 4'h9;

  // bus address of the first unit; the second unit is one above
  localparam logic [6:0] I2C_ADDR_BASE = 7'h48;

  // receive buffer: port tag plus data byte
  localparam int FIFO_W = 9;
  localparam int FIFO_D = 4;

  // register port byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_CFG = 4'h8;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_FLUSH = 1;
  localparam logic CTRL_RUN_RST = 1'b1;

endpackage : dsib_pkg

// ### rtl/dsib_fifo.sv
module dsib_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  // occupancy
  output logic [$clog2(D):0] level
);

  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  // full and empty straight from the occupancy count
  assign in_ready = (count_r != (AW+1)'(D));
  assign out_valid = (count_r != '0);
  assign out_data = mem[rd_ptr_r];
  assign level = count_r;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage has no reset; only pointers and count carry state
  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wr_ptr_r] <= in_data;
  end

  // pointers wrap naturally for power-of-two depth
  always_ff @(posedge mclk)
  begin
    if (rst || flush)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + AW'(1);
      if (pop)
        rd_ptr_r <= rd_ptr_r + AW'(1);
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : dsib_fifo

// ### rtl/dsib_bridge.sv
// Implementation choices: the placing of the registers and the plain strobed port.
module dsib_bridge #(
  parameter int P_DIV_9600 = dsib_pkg::DIV_9600,
  parameter int P_DIV_4800 = dsib_pkg::DIV_4800,
  parameter int P_DIV_2400 = dsib_pkg::DIV_2400,
  parameter int P_DIV_1200 = dsib_pkg::DIV_1200
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // configuration switches, on = 1
  input wire logic [7:0] config_switch_bank,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // serial ports
  input wire logic computer_rx,
  output logic computer_tx,
  input wire logic gps_rx,
  output logic gps_tx,
  // two-wire host bus, open drain data
  input wire logic i2c_scl,
  input wire logic i2c_sda_in,
  output logic i2c_sda_out,
  output logic i2c_sda_oe
);

  typedef enum logic [2:0] {
    I_IDLE = 3'b000,
    I_ADDR = 3'b001,
    I_AACK = 3'b010,
    I_WR = 3'b011,
    I_WACK = 3'b100,
    I_RD = 3'b101,
    I_RACK = 3'b110
  } dsib_i2c_st_e;

  localparam int NP = dsib_pkg::NPORTS;

  // configuration and control state
  logic cfg_valid_r;
  logic [7:0] cfg_r;
  logic run_r;
  logic flush_r;
  logic [NP-1:0] ovr_sticky_r;
  logic [NP-1:0] frm_sticky_r;
  logic last_tag_r;
  logic [31:0] rdata_r;
  logic [NP-1:0] port_en;
  logic [6:0] unit_addr;
  logic [NP-1:0] rx_pins;
  logic [1:0] baud_code [NP];

  // receive and transmit exchange with the per-port logic
  logic [NP-1:0] hold_v;
  logic [7:0] hold_d [NP];
  logic [NP-1:0] hold_take;
  logic [NP-1:0] ovr_ev;
  logic [NP-1:0] frm_ev;
  logic [NP-1:0] txq_v;
  logic [NP-1:0] tx_load;
  logic [NP-1:0] tx_pin;
  logic rr_r;
  logic pick;

  // buffer signals
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [dsib_pkg::FIFO_W-1:0] fifo_out_data;
  logic [2:0] fifo_level;

  // bus slave state
  dsib_i2c_st_e st_r;
  logic scl_q_r;
  logic sda_q_r;
  logic [7:0] sh_r;
  logic [3:0] cnt_r;
  logic rw_r;
  logic first_r;
  logic sel_r;
  logic sda_oe_r;
  logic sda_out_r;
  logic rise;
  logic fall;
  logic bus_start;
  logic bus_stop;
  logic load_now;
  logic wr_done;
  logic [7:0] rd_byte;

  // switches caught once, the first edge after reset release
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cfg_valid_r <= 1'b0;
      cfg_r <= dsib_pkg::SW_RST;
    end
    else if (!cfg_valid_r)
    begin
      cfg_r <= config_switch_bank;
      cfg_valid_r <= 1'b1;
    end
  end

  // nothing moves until the configuration is in place
  assign port_en[dsib_pkg::PORT_COMP] = cfg_valid_r && run_r
    && !cfg_r[dsib_pkg::SW_COMP_OFF];
  assign port_en[dsib_pkg::PORT_GPS] = cfg_valid_r && run_r
    && !cfg_r[dsib_pkg::SW_GPS_OFF];
  assign unit_addr = dsib_pkg::I2C_ADDR_BASE + 7'(cfg_r[dsib_pkg::SW_ADDR]);
  assign rx_pins = {gps_rx, computer_rx};
  assign baud_code[dsib_pkg::PORT_GPS] = {cfg_r[dsib_pkg::SW_GPS_BAUD_HI],
    cfg_r[dsib_pkg::SW_GPS_BAUD_LO]};
  assign baud_code[dsib_pkg::PORT_COMP] = {cfg_r[dsib_pkg::SW_COMP_BAUD_HI],
    cfg_r[dsib_pkg::SW_COMP_BAUD_LO]};

  // bit period in clocks for a baud select code
  function automatic logic [dsib_pkg::DIV_W-1:0] bit_div(input logic [1:0] code);
    logic [dsib_pkg::DIV_W-1:0] d;
    case (code)
      dsib_pkg::BAUD_SEL_9600: d = dsib_pkg::DIV_W'(P_DIV_9600);
      dsib_pkg::BAUD_SEL_4800: d = dsib_pkg::DIV_W'(P_DIV_4800);
      dsib_pkg::BAUD_SEL_2400: d = dsib_pkg::DIV_W'(P_DIV_2400);
      default: d = dsib_pkg::DIV_W'(P_DIV_1200);
    endcase
    return d;
  endfunction : bit_div

  genvar g;
  generate
    for (g = 0; g < NP; g++)
    begin : g_port
      logic [dsib_pkg::DIV_W-1:0] div;
      logic rbusy_r;
      logic [dsib_pkg::DIV_W-1:0] rcnt_r;
      logic [3:0] rbit_r;
      logic [7:0] rsh_r;
      logic [7:0] hold_r;
      logic hv_r;
      logic ovr_r;
      logic frm_r;
      logic [7:0] q_r;
      logic qv_r;
      logic tbusy_r;
      logic [dsib_pkg::DIV_W-1:0] tcnt_r;
      logic [3:0] tleft_r;
      logic [9:0] tsh_r;
      logic tpin_r;

      assign div = bit_div(baud_code[g]);
      assign hold_v[g] = hv_r;
      assign hold_d[g] = hold_r;
      assign ovr_ev[g] = ovr_r;
      assign frm_ev[g] = frm_r;
      assign txq_v[g] = qv_r;
      assign tx_pin[g] = tpin_r;

      // receiver: mid-bit sampling, start, 8 data, one stop, no parity
      always_ff @(posedge mclk)
      begin
        if (rst)
        begin
          rbusy_r <= 1'b0;
          rcnt_r <= '0;
          rbit_r <= 4'h0;
          rsh_r <= 8'h00;
          hold_r <= 8'h00;
          hv_r <= 1'b0;
          ovr_r <= 1'b0;
          frm_r <= 1'b0;
        end
        else
        begin
          ovr_r <= 1'b0;
          frm_r <= 1'b0;
          if (hold_take[g])
            hv_r <= 1'b0;
          if (!port_en[g])
            rbusy_r <= 1'b0;
          else if (!rbusy_r)
          begin
            if (!rx_pins[g])
            begin
              rbusy_r <= 1'b1;
              rcnt_r <= div >> 1;
              rbit_r <= 4'h0;
            end
          end
          else if (rcnt_r != '0)
            rcnt_r <= rcnt_r - dsib_pkg::DIV_W'(1);
          else
          begin
            rcnt_r <= div - dsib_pkg::DIV_W'(1);
            if (rbit_r == 4'h0)
            begin
              // a glitch shorter than half a bit is not a start
              if (rx_pins[g])
                rbusy_r <= 1'b0;
              else
                rbit_r <= 4'h1;
            end
            else if (rbit_r != dsib_pkg::UART_LAST_BIT)
            begin
              rsh_r <= {rx_pins[g], rsh_r[7:1]};
              rbit_r <= rbit_r + 4'h1;
            end
            else
            begin
              rbusy_r <= 1'b0;
              if (!rx_pins[g])
                frm_r <= 1'b1;
              else if (hv_r && !hold_take[g])
                ovr_r <= 1'b1;
              else
              begin
                hold_r <= rsh_r;
                hv_r <= 1'b1;
              end
            end
          end
        end
      end

      // transmit queue word, loaded from the host bus
      always_ff @(posedge mclk)
      begin
        if (rst)
        begin
          q_r <= 8'h00;
          qv_r <= 1'b0;
        end
        else if (tx_load[g])
        begin
          q_r <= sh_r;
          qv_r <= 1'b1;
        end
        else if (!tbusy_r && qv_r)
          qv_r <= 1'b0;
      end

      // transmitter: start bit, 8 data lsb first, one stop bit
      always_ff @(posedge mclk)
      begin
        if (rst)
        begin
          tbusy_r <= 1'b0;
          tcnt_r <= '0;
          tleft_r <= 4'h0;
          tsh_r <= 10'h3FF;
          tpin_r <= 1'b1;
        end
        else if (!tbusy_r)
        begin
          if (qv_r)
          begin
            tbusy_r <= 1'b1;
            tsh_r <= {1'b1, q_r, 1'b0};
            tpin_r <= 1'b0;
            tleft_r <= dsib_pkg::TX_SHIFTS;
            tcnt_r <= div - dsib_pkg::DIV_W'(1);
          end
        end
        else if (tcnt_r != '0)
          tcnt_r <= tcnt_r - dsib_pkg::DIV_W'(1);
        else if (tleft_r == 4'h0)
          tbusy_r <= 1'b0;
        else
        begin
          tsh_r <= {1'b1, tsh_r[9:1]};
          tpin_r <= tsh_r[1];
          tleft_r <= tleft_r - 4'h1;
          tcnt_r <= div - dsib_pkg::DIV_W'(1);
        end
      end
    end
  endgenerate

  assign computer_tx = tx_pin[dsib_pkg::PORT_COMP];
  assign gps_tx = tx_pin[dsib_pkg::PORT_GPS];

  // alternate between ports so neither can starve the other
  assign pick = hold_v[1] && (!hold_v[0] || rr_r);
  assign fifo_in_valid = |hold_v;
  assign hold_take[0] = fifo_in_valid && fifo_in_ready && !pick;
  assign hold_take[1] = fifo_in_valid && fifo_in_ready && pick;

  always_ff @(posedge mclk)
  begin
    if (rst)
      rr_r <= 1'b0;
    else if (fifo_in_valid && fifo_in_ready)
      rr_r <= !pick;
  end

  // full buffer stalls the receive holding words, not the data
  dsib_fifo #(
    .W(dsib_pkg::FIFO_W),
    .D(dsib_pkg::FIFO_D)
  ) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .flush(flush_r),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data({pick, hold_d[pick]}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // bus edges and framing conditions, inputs already synchronous
  assign rise = i2c_scl && !scl_q_r;
  assign fall = !i2c_scl && scl_q_r;
  assign bus_start = i2c_scl && scl_q_r && sda_q_r && !i2c_sda_in;
  assign bus_stop = i2c_scl && scl_q_r && !sda_q_r && i2c_sda_in;
  assign load_now = fall && !bus_start && !bus_stop
    && ((st_r == I_AACK && rw_r) || st_r == I_RACK);
  assign fifo_pop = load_now && fifo_out_valid;
  // empty buffer reads back as zero
  assign rd_byte = fifo_out_valid ? fifo_out_data[7:0] : 8'h00;
  assign wr_done = fall && !bus_start && !bus_stop && st_r == I_WR
    && cnt_r == 4'h8 && !first_r;
  assign tx_load[0] = wr_done && !sel_r && port_en[0] && !txq_v[0];
  assign tx_load[1] = wr_done && sel_r && port_en[1] && !txq_v[1];

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end
    else
    begin
      scl_q_r <= i2c_scl;
      sda_q_r <= i2c_sda_in;
    end
  end

  // bus slave: address, then on writes a port select byte, then data bytes
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_r <= I_IDLE;
      sh_r <= 8'h00;
      cnt_r <= 4'h0;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      sel_r <= 1'b0;
      sda_oe_r <= 1'b0;
      last_tag_r <= 1'b0;
    end
    else if (bus_start && cfg_valid_r)
    begin
      st_r <= I_ADDR;
      cnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
    end
    else if (bus_stop)
    begin
      st_r <= I_IDLE;
      sda_oe_r <= 1'b0;
    end
    else if (load_now)
    begin
      // data changes only while the clock is low
      st_r <= I_RD;
      sda_oe_r <= !rd_byte[7];
      sh_r <= {rd_byte[6:0], 1'b0};
      cnt_r <= 4'h1;
      if (fifo_out_valid)
        last_tag_r <= fifo_out_data[8];
    end
    else
    begin
      case (st_r)
        I_ADDR, I_WR:
        begin
          if (rise && cnt_r != 4'h8)
          begin
            sh_r <= {sh_r[6:0], i2c_sda_in};
            cnt_r <= cnt_r + 4'h1;
          end
          else if (fall && cnt_r == 4'h8)
          begin
            if (st_r == I_ADDR)
            begin
              // unmatched address: stay off the bus until the next start
              if (sh_r[7:1] == unit_addr)
              begin
                st_r <= I_AACK;
                sda_oe_r <= 1'b1;
                rw_r <= sh_r[0];
                first_r <= 1'b1;
              end
              else
                st_r <= I_IDLE;
            end
            else if (first_r)
            begin
              sel_r <= sh_r[0];
              first_r <= 1'b0;
              st_r <= port_en[sh_r[0]] ? I_WACK : I_IDLE;
              sda_oe_r <= port_en[sh_r[0]];
            end
            else
            begin
              // busy or disabled port: not acknowledged, byte refused
              st_r <= (tx_load != '0) ? I_WACK : I_IDLE;
              sda_oe_r <= (tx_load != '0);
            end
          end
        end
        I_AACK, I_WACK:
        begin
          if (fall)
          begin
            st_r <= I_WR;
            sda_oe_r <= 1'b0;
            cnt_r <= 4'h0;
          end
        end
        I_RD:
        begin
          if (fall)
          begin
            if (cnt_r == 4'h8)
            begin
              st_r <= I_RACK;
              sda_oe_r <= 1'b0;
            end
            else
            begin
              sda_oe_r <= !sh_r[7];
              sh_r <= {sh_r[6:0], 1'b0};
              cnt_r <= cnt_r + 4'h1;
            end
          end
        end
        I_RACK:
        begin
          if (rise && i2c_sda_in)
            st_r <= I_IDLE;
        end
        default:
          st_r <= I_IDLE;
      endcase
    end
  end

  // open drain: the data line is only ever pulled low
  always_ff @(posedge mclk)
  begin
    sda_out_r <= 1'b0;
  end

  assign i2c_sda_out = sda_out_r;
  assign i2c_sda_oe = sda_oe_r;

  // control register and sticky error flags, set beats clear
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      run_r <= dsib_pkg::CTRL_RUN_RST;
      flush_r <= 1'b0;
      ovr_sticky_r <= '0;
      frm_sticky_r <= '0;
    end
    else
    begin
      flush_r <= reg_wr && reg_addr == dsib_pkg::REG_CTRL && reg_wdata[dsib_pkg::CTRL_FLUSH];
      if (reg_wr && reg_addr == dsib_pkg::REG_CTRL)
        run_r <= reg_wdata[dsib_pkg::CTRL_RUN];
      if (reg_wr && reg_addr == dsib_pkg::REG_STATUS)
      begin
        ovr_sticky_r <= (ovr_sticky_r & ~reg_wdata[1:0]) | ovr_ev;
        frm_sticky_r <= (frm_sticky_r & ~reg_wdata[3:2]) | frm_ev;
      end
      else
      begin
        ovr_sticky_r <= ovr_sticky_r | ovr_ev;
        frm_sticky_r <= frm_sticky_r | frm_ev;
      end
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (rst || !reg_rd)
      rdata_r <= 32'h0000_0000;
    else
    begin
      case (reg_addr)
        dsib_pkg::REG_CTRL: rdata_r <= {31'h0, run_r};
        dsib_pkg::REG_STATUS: rdata_r <= {23'h0, last_tag_r, cfg_valid_r, fifo_level,
          frm_sticky_r, ovr_sticky_r};
        dsib_pkg::REG_CFG: rdata_r <= {24'h0, cfg_r};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign reg_rdata = rdata_r;

endmodule : dsib_bridge

// ### testbench/dsib_bridge_monitor.sv
module dsib_bridge_monitor #(
  parameter int P_DIV_9600 = 16,
  parameter int P_DIV_4800 = 32,
  parameter int P_DIV_2400 = 64,
  parameter int P_DIV_1200 = 128
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // switches and register port
  input wire logic [7:0] config_switch_bank,
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // serial outputs, bus clock and data enable
  input wire logic computer_tx,
  input wire logic gps_tx,
  input wire logic i2c_scl,
  input wire logic i2c_sda_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic cap_r;
  logic [7:0] cfg_r;
  int comp_lo_r;
  int gps_lo_r;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // bit period for a two-switch baud code
  function automatic int div_of(input logic [1:0] code);
    return code == 2'h3 ? P_DIV_9600 : code == 2'h2 ? P_DIV_4800 :
      code == 2'h1 ? P_DIV_2400 : P_DIV_1200;
  endfunction : div_of

  // switches as captured at the first edge out of reset
  always_ff @(posedge mclk)
  begin
    if (rst)
      cap_r <= 1'b0;
    else if (!cap_r)
    begin
      cap_r <= 1'b1;
      cfg_r <= config_switch_bank;
    end
  end

  // low runs on tx; zero data bits merge with start, so whole periods only
  always_ff @(posedge mclk)
  begin
    comp_lo_r <= (rst || computer_tx) ? 0 : comp_lo_r + 1;
    gps_lo_r <= (rst || gps_tx) ? 0 : gps_lo_r + 1;
  end

  sequence s_quiet;
    computer_tx && gps_tx && !i2c_sda_oe;
  endsequence
  sequence s_cfg_rd;
    reg_rd && reg_addr == dsib_pkg::REG_CFG && cap_r;
  endsequence
  property p_quiet;
    $fell(rst) |-> s_quiet [*2];
  endproperty
  a_quiet: assert property (p_quiet) else $error("active just after reset");
  property p_cfg_read;
    s_cfg_rd |=> reg_rdata[7:0] == cfg_r;
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("switch readback wrong");
  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  property p_comp_bits;
    $rose(computer_tx) && cap_r |-> comp_lo_r % div_of(cfg_r[6:5]) == 0;
  endproperty
  a_comp_bits: assert property (p_comp_bits) else $error("computer bit length");
  property p_gps_bits;
    $rose(gps_tx) && cap_r |-> gps_lo_r % div_of(cfg_r[4:3]) == 0;
  endproperty
  a_gps_bits: assert property (p_gps_bits) else $error("gps bit length");
  property p_gps_off;
    cap_r && cfg_r[dsib_pkg::SW_GPS_OFF] |-> gps_tx;
  endproperty
  a_gps_off: assert property (p_gps_off) else $error("disabled gps port sends");
  property p_comp_off;
    cap_r && cfg_r[dsib_pkg::SW_COMP_OFF] |-> computer_tx;
  endproperty
  a_comp_off: assert property (p_comp_off) else $error("disabled port sends");
  property p_sda_stable;
    $changed(i2c_sda_oe) |-> !i2c_scl && !$past(i2c_scl);
  endproperty
  a_sda_stable: assert property (p_sda_stable) else $error("data moved, clock high");
endmodule : dsib_bridge_monitor

bind dsib_bridge dsib_bridge_monitor #(.P_DIV_9600(P_DIV_9600), .P_DIV_4800(P_DIV_4800),
  .P_DIV_2400(P_DIV_2400), .P_DIV_1200(P_DIV_1200)) u_dsib_bridge_monitor (.mclk(mclk),
  .rst(rst), .config_switch_bank(config_switch_bank), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .computer_tx(computer_tx), .gps_tx(gps_tx), .i2c_scl(i2c_scl),
  .i2c_sda_oe(i2c_sda_oe));

// ### testbench/dsib_peer.sv
module dsib_peer (
  // clock
  input wire logic mclk,
  // serial lines of one computer or gps port, idle high
  output logic to_dut,
  input wire logic from_dut
);
  timeunit 1ns;
  timeprecision 1ns;
  int div = 16;
  initial to_dut = 1'b1;

  // start, eight data lsb first, one stop, no parity
  task automatic send(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge mclk);
      to_dut <= frame[i];
      repeat (div - 1) @(posedge mclk);
    end
  endtask : send

  // bounded wait for a start, then sample each bit mid-period
  task automatic recv(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    while (from_dut !== 1'b0 && n < 20000)
    begin
      @(posedge mclk);
      n++;
    end
    if (n < 20000)
    begin
      repeat (div / 2) @(posedge mclk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (div) @(posedge mclk);
        b[i] = from_dut;
      end
      repeat (div) @(posedge mclk);
      ok = (from_dut === 1'b1);
    end
  endtask : recv
endmodule : dsib_peer

// ### testbench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DIV_FAST = 16;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sw = 8'h00;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic scl = 1'b1;
  logic sda_m = 1'b1;
  logic [31:0] reg_rdata;
  logic computer_rx, computer_tx, gps_rx, gps_tx, sda_out, sda_oe, sda_w;
  logic [6:0] addr7 = 7'h00;
  logic [7:0] cfgs [5] = '{8'h60, 8'h3D, 8'h52, 8'h0C, 8'h58};
  logic [8:0] q [$];
  logic [31:0] st;
  logic [7:0] rb;
  logic ack, cen, gen;
  int cdiv, gdiv;
  int miscompares = 0;
  int samples_checked = 0;

  // open-drain data wire with pull-up
  assign sda_w = !((sda_oe && !sda_out) || !sda_m);
  always #25 mclk = ~mclk;

  dsib_bridge #(.P_DIV_9600(DIV_FAST), .P_DIV_4800(DIV_FAST * 2), .P_DIV_2400(DIV_FAST * 4),
    .P_DIV_1200(DIV_FAST * 8)) u_dsib_bridge (.mclk(mclk), .rst(rst), .config_switch_bank(sw),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .computer_rx(computer_rx), .computer_tx(computer_tx),
    .gps_rx(gps_rx), .gps_tx(gps_tx), .i2c_scl(scl), .i2c_sda_in(sda_w),
    .i2c_sda_out(sda_out), .i2c_sda_oe(sda_oe));
  dsib_peer u_dsib_peer_comp (.mclk(mclk), .to_dut(computer_rx), .from_dut(computer_tx));
  dsib_peer u_dsib_peer_gps (.mclk(mclk), .to_dut(gps_rx), .from_dut(gps_tx));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    if (miscompares == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // every task starts and ends just after a rising edge
  task automatic clk(input int n);
    repeat (n) @(posedge mclk);
  endtask : clk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    clk(1);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    reg_rd <= 1'b1;
    reg_addr <= a;
    clk(1);
    reg_rd <= 1'b0;
    // read data stand for this one cycle only; take them mid-cycle
    @(negedge mclk);
    d = reg_rdata;
    clk(1);
  endtask : rd

  // bus bit: data set while clock low, sampled at the end of clock high
  task automatic i2c_bit(input logic b, output logic r);
    sda_m <= b;
    clk(4);
    scl <= 1'b1;
    clk(4);
    r = sda_w;
    scl <= 1'b0;
    clk(4);
  endtask : i2c_bit

  // lvl 0 gives a start condition, lvl 1 a stop condition
  task automatic i2c_cond(input logic lvl);
    sda_m <= !lvl;
    clk(4);
    scl <= 1'b1;
    clk(4);
    sda_m <= lvl;
    clk(4);
    scl <= lvl;
    clk(4);
  endtask : i2c_cond

  task automatic i2c_tx(input logic [7:0] b, output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--)
      i2c_bit(b[i], r);
    i2c_bit(1'b1, r);
    ak = !r;
  endtask : i2c_tx

  task automatic i2c_rx(output logic [7:0] b, input logic last);
    logic r;
    for (int i = 7; i >= 0; i--)
      i2c_bit(1'b1, b[i]);
    i2c_bit(last, r);
  endtask : i2c_rx

  // bus write of one byte to a port while its peer listens on tx
  task automatic port_write(input int p, input logic en);
    logic [7:0] b;
    logic ok;
    logic a;
    b = 8'h00;
    ok = 1'b0;
    fork
      if (en && p == 0)
        u_dsib_peer_comp.recv(b, ok);
      else if (en)
        u_dsib_peer_gps.recv(b, ok);
      begin
        i2c_cond(1'b0);
        i2c_tx({addr7, 1'b0}, a);
        check(a, 1'b1);
        i2c_tx(8'(p), a);
        check(a, en);
        if (a === 1'b1)
        begin
          i2c_tx(8'h5A ^ 8'(p), a);
          check(a, 1'b1);
        end
        i2c_cond(1'b1);
      end
    join
    if (en)
      check({ok, b}, {1'b1, 8'h5A ^ 8'(p)});
    if (en && ok !== 1'b1)
      print_verdict();
  endtask : port_write

  initial
  begin
    foreach (cfgs[c])
    begin
      rst <= 1'b1;
      sw <= cfgs[c];
      clk(2);
      rst <= 1'b0;
      clk(2);
      cen = !sw[dsib_pkg::SW_COMP_OFF];
      gen = !sw[dsib_pkg::SW_GPS_OFF];
      cdiv = DIV_FAST << (3 - sw[6:5]);
      gdiv = DIV_FAST << (3 - sw[4:3]);
      addr7 = dsib_pkg::I2C_ADDR_BASE + 7'(sw[dsib_pkg::SW_ADDR]);
      u_dsib_peer_comp.div = cdiv;
      u_dsib_peer_gps.div = gdiv;
      rd(dsib_pkg::REG_CFG, st);
      check(st, {24'h0, sw});
      rd(4'hC, st);
      check(st, 32'h0);
      fork
        u_dsib_peer_comp.send(8'hA5);
        u_dsib_peer_gps.send(8'h3C);
      join
      clk(4);
      // arrival order follows the faster baud rate; bit 8 marks gps
      q.delete();
      if (cen)
        q.push_back(9'h0A5);
      if (gen && cen && gdiv < cdiv)
        q.push_front(9'h13C);
      else if (gen)
        q.push_back(9'h13C);
      rd(dsib_pkg::REG_STATUS, st);
      check(st[6:4], q.size());
      check(st[3:0], 4'h0);
      i2c_cond(1'b0);
      i2c_tx({addr7, 1'b1}, ack);
      check(ack, 1'b1);
      for (int i = 0; i < 2; i++)
      begin
        i2c_rx(rb, i == 1);
        check(rb, i < q.size() ? q[i][7:0] : 8'h00);
      end
      i2c_cond(1'b1);
      rd(dsib_pkg::REG_STATUS, st);
      check(st[8], q[q.size() - 1][8]);
      i2c_cond(1'b0);
      i2c_tx({addr7 ^ 7'h01, 1'b0}, ack);
      check(ack, 1'b0);
      i2c_cond(1'b1);
      port_write(0, cen);
      port_write(1, gen);
      // stopped processing refuses writes even to an enabled port
      wr(dsib_pkg::REG_CTRL, 32'h0);
      rd(dsib_pkg::REG_CTRL, st);
      check(st, 32'h0);
      port_write(0, 1'b0);
      wr(dsib_pkg::REG_CTRL, 32'h1);
    end
    // flush empties the buffer and reads back as zero; run stays set
    u_dsib_peer_comp.send(8'h81);
    clk(4);
    rd(dsib_pkg::REG_STATUS, st);
    check(st[6:4], 3'h1);
    wr(dsib_pkg::REG_CTRL, 32'h3);
    rd(dsib_pkg::REG_CTRL, st);
    check(st, 32'h1);
    rd(dsib_pkg::REG_STATUS, st);
    check(st[6:4], 3'h0);
    print_verdict();
  end
endmodule : tb_top
